// ---- rtl/pif_flags.sv ----
// Two peripheral interrupt request flag registers behind an AHB-Lite slave.
// Assumes event sources run on hclk and present one-cycle pulses or levels.
//
// The placing of the registers and register access over AHB-Lite were decided locally.
`timescale 1ns/1ps

// What this block does
// - Flags set regardless of any enable bit
// - All flags clear on every reset
// - Unimplemented bits read zero, ignore writes
// - Logic cell flags set, held until cleared
// - Timer gate flags set when gate closes
// - Capture mode sets channel flag on capture
// - Compare mode sets channel flag on match
// - PWM mode sets flag on trailing edge
module pif_flags (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic soft_reset,
  input wire logic hsel,
  input wire logic [pif_pkg::PIF_ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [pif_pkg::PIF_DATA_W-1:0] hwdata,
  input wire logic hready,
  output logic [pif_pkg::PIF_DATA_W-1:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [pif_pkg::PIF_CELLS-1:0] logic_cell_event,
  input wire logic [pif_pkg::PIF_GATES-1:0] timer_gate_active,
  input wire logic [pif_pkg::PIF_CHANS-1:0] capcomp_capture_event,
  input wire logic [pif_pkg::PIF_CHANS-1:0] capcomp_compare_match,
  input wire logic [pif_pkg::PIF_CHANS-1:0] capcomp_pwm_output,
  input wire logic [pif_pkg::PIF_CHANS*pif_pkg::PIF_MODE_W-1:0] capcomp_mode_select,
  output logic [pif_pkg::PIF_FLAG_W-1:0] periph_irq_req_five,
  output logic [pif_pkg::PIF_FLAG_W-1:0] periph_irq_req_six
);
  import pif_pkg::*;

  logic [PIF_FLAG_W-1:0] five_q;
  logic [PIF_FLAG_W-1:0] five_d;
  logic [PIF_FLAG_W-1:0] six_q;
  logic [PIF_FLAG_W-1:0] six_d;
  logic [PIF_FLAG_W-1:0] set_five;
  logic [PIF_FLAG_W-1:0] set_six;
  logic [PIF_GATES-1:0] gate_prev_q;
  logic [PIF_CHANS-1:0] pwm_prev_q;
  logic [PIF_CHANS-1:0] chan_event;
  logic addr_ok;
  logic wr_pend_q;
  logic rd_pend_q;
  logic [PIF_DEC_MSB:0] dp_addr_q;
  logic [PIF_DATA_W-1:0] hrdata_q;
  logic hreadyout_q;
  logic hresp_q;
  logic wr_five;
  logic wr_six;

  // New flag value: a write replaces implemented bits, then events are ORed on top.
  function automatic logic [PIF_FLAG_W-1:0] flag_next(
    input logic [PIF_FLAG_W-1:0] cur,
    input logic [PIF_FLAG_W-1:0] set,
    input logic wr,
    input logic [PIF_FLAG_W-1:0] wdata,
    input logic [PIF_FLAG_W-1:0] mask
  );
    logic [PIF_FLAG_W-1:0] base;
    base = wr ? wdata : cur;
    return (base | set) & mask;
  endfunction

  // Any valid transfer is taken; the single master only issues NONSEQ.
  assign addr_ok = hsel && hready && htrans[1];

  // Gate and PWM history to find the falling edges.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gate_prev_q <= '0;
      pwm_prev_q <= '0;
    end else begin
      gate_prev_q <= timer_gate_active;
      pwm_prev_q <= capcomp_pwm_output;
    end
  end

  // Channel event source depends on its selected mode.
  generate
    for (genvar i = 0; i < PIF_CHANS; i++) begin : g_chan
      logic [PIF_MODE_W-1:0] mode;
      assign mode = capcomp_mode_select[i*PIF_MODE_W +: PIF_MODE_W];
      always_comb begin
        case (mode)
          PIF_MODE_CAPTURE: chan_event[i] = capcomp_capture_event[i];
          PIF_MODE_COMPARE: chan_event[i] = capcomp_compare_match[i];
          PIF_MODE_PWM: chan_event[i] = pwm_prev_q[i] && !capcomp_pwm_output[i];
          default: chan_event[i] = 1'b0;
        endcase
      end
    end
  endgenerate

  // Set vectors ignore every enable; no enable reaches this block.
  always_comb begin
    set_five = '0;
    set_six = '0;
    set_five[PIF_CELL_LSB +: PIF_CELLS] = logic_cell_event;
    set_five[PIF_GATE_LSB +: PIF_GATES] = gate_prev_q & ~timer_gate_active;
    set_six[PIF_CHAN_LSB +: PIF_CHANS] = chan_event;
  end

  assign wr_five = wr_pend_q && (dp_addr_q == PIF_OFS_FIVE);
  assign wr_six = wr_pend_q && (dp_addr_q == PIF_OFS_SIX);

  assign five_d = flag_next(five_q, set_five, wr_five, hwdata[PIF_FLAG_W-1:0], PIF_MASK_FIVE);
  assign six_d = flag_next(six_q, set_six, wr_six, hwdata[PIF_FLAG_W-1:0], PIF_MASK_SIX);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      five_q <= PIF_RST_FIVE;
      six_q <= PIF_RST_SIX;
    end else if (soft_reset) begin
      five_q <= PIF_RST_FIVE;
      six_q <= PIF_RST_SIX;
    end else begin
      five_q <= five_d;
      six_q <= six_d;
    end
  end

  // Bus phase tracking. Reads take one wait state so the returned value already
  // includes a write made in the cycle before.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      dp_addr_q <= '0;
      hreadyout_q <= 1'b1;
    end else begin
      wr_pend_q <= addr_ok && hwrite;
      rd_pend_q <= addr_ok && !hwrite;
      if (addr_ok) begin
        dp_addr_q <= haddr[PIF_DEC_MSB:0];
      end
      hreadyout_q <= !(addr_ok && !hwrite);
    end
  end

  // Read data; unmapped addresses and unimplemented bits read zero.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_q <= '0;
    end else if (rd_pend_q) begin
      case (dp_addr_q)
        PIF_OFS_FIVE: hrdata_q <= {24'h000000, five_q & PIF_MASK_FIVE};
        PIF_OFS_SIX: hrdata_q <= {24'h000000, six_q & PIF_MASK_SIX};
        default: hrdata_q <= '0;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hresp_q <= PIF_HRESP_OKAY;
    end else begin
      hresp_q <= PIF_HRESP_OKAY;
    end
  end

  assign hrdata = hrdata_q;
  assign hreadyout = hreadyout_q;
  assign hresp = hresp_q;
  assign periph_irq_req_five = five_q;
  assign periph_irq_req_six = six_q;

endmodule

// ---- rtl/pif_pkg.sv ----
// Constants and types for the peripheral interrupt flag registers.
// Assumes one AHB-Lite slave port with 32-bit data and one system clock.
package pif_pkg;

  localparam int unsigned PIF_ADDR_W = 32;
  localparam int unsigned PIF_DATA_W = 32;
  localparam int unsigned PIF_FLAG_W = 8;
  localparam int unsigned PIF_CELLS = 4;
  localparam int unsigned PIF_GATES = 3;
  localparam int unsigned PIF_CHANS = 5;
  localparam int unsigned PIF_MODE_W = 2;

  // Byte addresses of the two flag registers.
  localparam logic [11:0] PIF_OFS_FIVE = 12'h000;
  localparam logic [11:0] PIF_OFS_SIX = 12'h004;
  localparam int unsigned PIF_DEC_MSB = 11;

  // Field positions inside the logic cell and timer gate register.
  localparam int unsigned PIF_CELL_LSB = 4;
  localparam int unsigned PIF_GATE_LSB = 0;
  // Field position inside the capture/compare/PWM register.
  localparam int unsigned PIF_CHAN_LSB = 0;

  // Implemented bits; all others read zero and drop writes.
  localparam logic [7:0] PIF_MASK_FIVE = 8'hf7;
  localparam logic [7:0] PIF_MASK_SIX = 8'h1f;
  localparam logic [7:0] PIF_RST_FIVE = 8'h00;
  localparam logic [7:0] PIF_RST_SIX = 8'h00;

  // AHB-Lite transfer and response codes.
  localparam logic [1:0] PIF_HTRANS_NONSEQ = 2'h2;
  localparam logic PIF_HRESP_OKAY = 1'h0;

  // Capture/compare/PWM channel mode.
  typedef enum logic [1:0] {
    PIF_MODE_OFF = 2'h0,
    PIF_MODE_CAPTURE = 2'h1,
    PIF_MODE_COMPARE = 2'h3,
    PIF_MODE_PWM = 2'h2
  } pif_mode_e;

endpackage

// ---- tb/pif_flags_props.sv ----
// Checker on the flag block ports.
// Assumes one clock with hresetn as its reset.
`timescale 1ns/1ps
module pif_flags_props (
  input logic hclk,
  input logic hresetn,
  input logic soft_reset,
  input logic hsel,
  input logic [1:0] htrans,
  input logic hwrite,
  input logic hready,
  input logic hreadyout,
  input logic [3:0] logic_cell_event,
  input logic [2:0] timer_gate_active,
  input logic [4:0] capcomp_capture_event,
  input logic [4:0] capcomp_compare_match,
  input logic [4:0] capcomp_pwm_output,
  input logic [9:0] capcomp_mode_select,
  input logic [7:0] periph_irq_req_five,
  input logic [7:0] periph_irq_req_six
);
  logic [4:0] pwm_q;
  logic [4:0] hit;
  logic [2:0] gate_q;
  logic [2:0] fall;
  logic req;
  assign fall = gate_q & ~timer_gate_active;
  assign req = hsel && hready && htrans[1];
  always_ff @(posedge hclk) pwm_q <= capcomp_pwm_output;
  always_ff @(posedge hclk) gate_q <= timer_gate_active;
  always_comb for (int i = 0; i < 5; i++) case (capcomp_mode_select[2*i+:2])
    2'h1: hit[i] = capcomp_capture_event[i];
    2'h3: hit[i] = capcomp_compare_match[i];
    2'h2: hit[i] = pwm_q[i] & ~capcomp_pwm_output[i];
    default: hit[i] = 1'b0;
  endcase
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_rsv_five:
    assert property (!periph_irq_req_five[3]) else $error("bit 3 set");
  a_rsv_six:
    assert property (periph_irq_req_six[7:5] == 3'h0) else $error("high bits set");
  a_cell_set:
    assert property (!soft_reset |=> (periph_irq_req_five[7:4] & $past(logic_cell_event)) == $past(logic_cell_event))
      else $error("cell flag missed");
  a_gate_set:
    assert property (!soft_reset |=> (periph_irq_req_five[2:0] & $past(fall)) == $past(fall)) else $error("gate missed");
  a_chan_set:
    assert property (!soft_reset |=> (periph_irq_req_six[4:0] & $past(hit)) == $past(hit)) else $error("chan missed");
  a_soft_clr:
    assert property (soft_reset |=> periph_irq_req_five == 8'h0 && periph_irq_req_six == 8'h0) else $error("not cleared");
  a_rd_wait:
    assert property (req && !hwrite |=> !hreadyout ##1 hreadyout) else $error("read wait wrong");
  a_wr_ready:
    assert property (req && hwrite |=> hreadyout) else $error("write stalled");
  c_cell: cover property (|logic_cell_event);
  c_fall: cover property (|fall);
  c_soft: cover property (soft_reset);
endmodule
bind pif_flags pif_flags_props u_props (.*);

// ---- tb/pif_flags_tb_top.sv ----
// Bench: events from the source model, software over AHB-Lite.
// Assumes the checker binds itself.
`timescale 1ns/1ps
module pif_flags_tb_top;
  logic hclk, hresetn, soft_reset, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [1:0] htrans;
  logic [2:0] hsize, kind, timer_gate_active;
  logic [4:0] bits, capcomp_capture_event, capcomp_compare_match, capcomp_pwm_output;
  logic [3:0] logic_cell_event;
  logic [9:0] capcomp_mode_select;
  logic [7:0] periph_irq_req_five, periph_irq_req_six;
  wire hready = hreadyout;
  int num_errors = 0;
  int cmp_count = 0;
  logic [33:0] rows [7] = '{{3'h1, 5'h05, 10'h155, 8'h50, 8'h00}, {3'h2, 5'h05, 10'h155, 8'h05, 8'h00},
    {3'h3, 5'h11, 10'h155, 8'h00, 8'h11}, {3'h4, 5'h0a, 10'h3ff, 8'h00, 8'h0a}, {3'h5, 5'h1f, 10'h2aa, 8'h00, 8'h1f},
    {3'h4, 5'h1f, 10'h155, 8'h00, 8'h00}, {3'h3, 5'h1f, 10'h000, 8'h00, 8'h00}};
  pif_flags dut (.*);
  pif_src u_src (.*);
  task chk(string n, logic [31:0] s, e);
    cmp_count++;
    if (s !== e) begin
      num_errors++;
      $display("[FAIL] %s exp %h got %h", n, e, s);
    end
  endtask
  task ahb(logic w, logic [31:0] a, d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge hclk); while (!hreadyout);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (!hreadyout);
    r = hrdata;
  endtask
  task rd(logic [31:0] a, e, string n);
    ahb(1'b0, a, 32'h0);
    chk(n, r, e);
  endtask
  task ev(logic [2:0] k, logic [4:0] b);
    kind <= k;
    bits <= b;
    @(posedge hclk);
    kind <= 3'h0;
  endtask
  task finish_test;
    $display("checks %0d errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end
  initial begin
    repeat (3000) @(posedge hclk);
    num_errors++;
    finish_test;
  end
  initial begin
    {hresetn, soft_reset, hsel, hwrite, haddr, hwdata, htrans, kind, bits, capcomp_mode_select} = '0;
    hsize = 3'h2;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    rd(32'h0, 32'h0, "five_rst");
    for (int i = 0; i < 7; i++) begin
      capcomp_mode_select <= rows[i][25:16];
      ev(rows[i][33:31], rows[i][30:26]);
      rd(32'h0, rows[i][15:8], "five");
      rd(32'h4, rows[i][7:0], "six");
      ahb(1'b1, 32'h0, 32'h0);
      ahb(1'b1, 32'h4, 32'h0);
      $display("row %0d done", i);
    end
    ahb(1'b1, 32'h0, 32'hff);
    rd(32'h0, 32'hf7, "five_rsv");
    ahb(1'b1, 32'h4, 32'hffff_ffff);
    rd(32'h4, 32'h1f, "six_rsv");
    rd(32'h8, 32'h0, "unmapped");
    soft_reset <= 1'b1;
    @(posedge hclk);
    soft_reset <= 1'b0;
    rd(32'h4, 32'h0, "six_soft");
    fork
      ahb(1'b1, 32'h0, 32'h0);
      begin
        @(posedge hclk);
        ev(3'h1, 5'h01);
      end
    join
    rd(32'h0, 32'h10, "set_wins");
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    chk("hrdata_rst", hrdata, 32'h0);
    chk("hresp_rst", {31'h0, hresp}, 32'h0);
    chk("hready_rst", {31'h0, hreadyout}, 32'h1);
    rd(32'h0, 32'h0, "five_rst2");
    chk("hresp_rd", {31'h0, hresp}, 32'h0);
    $display("special cases done");
    finish_test;
  end
endmodule

// ---- tb/pif_src.sv ----
// Event source model, one command per cycle.
// Assumes kind and bits change just after a rising edge.
`timescale 1ns/1ps
module pif_src (
  input logic hclk,
  input logic [2:0] kind,
  input logic [4:0] bits,
  output logic [3:0] logic_cell_event = 4'h0,
  output logic [2:0] timer_gate_active = 3'h7,
  output logic [4:0] capcomp_capture_event = 5'h0,
  output logic [4:0] capcomp_compare_match = 5'h0,
  output logic [4:0] capcomp_pwm_output = 5'h1f
);
  // Levels idle high, so only a commanded drop reads as a close or a trailing edge.
  always @(posedge hclk) begin
    logic_cell_event <= (kind == 3'h1) ? bits[3:0] : 4'h0;
    timer_gate_active <= (kind == 3'h2) ? ~bits[2:0] : 3'h7;
    capcomp_capture_event <= (kind == 3'h3) ? bits : 5'h0;
    capcomp_compare_match <= (kind == 3'h4) ? bits : 5'h0;
    capcomp_pwm_output <= (kind == 3'h5) ? ~bits : 5'h1f;
  end
endmodule
